// ---- include/sbm_pkg.sv ----
/*
  Constants, types and state layout for the serial-bus master and EEPROM loader.
  Assumes a 100 MHz core clock and open-drain pads with external pullups.
*/
// Functional notes
// - interface off unless strap pulled low and both lines read high
// - detection sets bus-detected flag, bit 3 of status; write 1 clears
// - strap low: clock on terminal four, data on terminal one
// - clock near 100 kHz during transfers; released when idle
// - each transfer opens with data falling while clock is high
// - each transfer ends with data rising while clock is high
// - data only changes while clock is low, except at start and stop
// - bytes are eight bits, each followed by an acknowledge bit
// - receiver acknowledges by holding data low through clock high
// - this block is the only master and makes the clock
// - software does byte reads and writes; only loader reads a run
// - write: start, address+0, ack, index, ack, data msb first, ack, stop
// - missing acknowledge sets error bit in control/status register
// - read uses direction bit 1; slave drives data; master acknowledges all but the last byte
// - after reset, if detected, load register defaults from EEPROM
// - EEPROM byte 00h is a flag: 01h load, FFh skip
// - byte 01h loads command bits 8,6,5,2,1,0; bit 8 from bit 7
// - bytes 02h-05h load subsystem vendor id and subsystem id, low first
// - bytes 06h-09h load legacy base, low first; bit 0 kept
// - bytes 0Ah and 0Bh load system control bits 7:0 and 15:8
// - a write to the slave-address register starts a transaction
package sbm_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SCL_HZ = 100_000;
  localparam int unsigned QTR_CYC = CLK_HZ / (4 * SCL_HZ);
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
  localparam logic [3:0] DET_LAST = 4'h7;
  localparam logic [6:0] EE_ADDR7 = 7'h50;
  localparam logic [7:0] EE_FIRST = 8'h00;
  localparam logic [7:0] FLAG_LOAD = 8'h01;
  localparam logic [3:0] OFF_FLAG = 4'h0;
  localparam logic [3:0] OFF_CMD = 4'h1;
  localparam logic [3:0] OFF_SVID_LO = 4'h2;
  localparam logic [3:0] OFF_SVID_HI = 4'h3;
  localparam logic [3:0] OFF_SID_LO = 4'h4;
  localparam logic [3:0] OFF_SID_HI = 4'h5;
  localparam logic [3:0] OFF_LEG0 = 4'h6;
  localparam logic [3:0] OFF_LEG1 = 4'h7;
  localparam logic [3:0] OFF_LEG2 = 4'h8;
  localparam logic [3:0] OFF_LEG3 = 4'h9;
  localparam logic [3:0] OFF_SYS_LO = 4'hA;
  localparam logic [3:0] OFF_LAST = 4'hB;
  localparam int CS_RD_VALID = 0;
  localparam int CS_ERROR = 1;
  localparam int CS_BUS_DETECTED_FLAG = 3;
  localparam int CS_BUSY = 5;
  localparam logic [7:0] CS_W1C_MASK = 8'h0B;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_TX = 3'b010,
    ST_RXACK = 3'b011,
    ST_RX = 3'b100,
    ST_TXACK = 3'b101,
    ST_STOP = 3'b110,
    ST_DET = 3'b111
  } sbm_state_t;

  typedef struct packed {
    logic [7:0] slave_addr;
    logic [7:0] index;
    logic [7:0] wdata;
  } sbm_sw_req_t;

  typedef struct packed {
    logic [8:0] command;
    logic [15:0] ss_vendor_id;
    logic [15:0] ss_id;
    logic [31:0] legacy_base;
    logic [15:0] sys_ctrl;
  } sbm_dflt_t;

  typedef struct packed {
    logic multifunction_terminal_four_o;
    logic multifunction_terminal_four_oe;
    logic multifunction_terminal_one_o;
    logic multifunction_terminal_one_oe;
  } sbm_pins_t;

  typedef struct packed {
    logic [2:0] sy1;
    logic [2:0] sy2;
    sbm_state_t st;
    logic [3:0] det_cnt;
    logic en;
    logic [7:0] tick;
    logic [1:0] q;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic [2:0] ph;
    logic ld;
    logic wr;
    logic last;
    logic nack;
    logic [3:0] cnt;
    sbm_sw_req_t req;
    logic [7:0] rdata;
    logic [7:0] csr;
    logic [1:0][11:0] fifo;
    logic wp;
    logic rp;
    logic [1:0] fn;
    logic ldone;
    sbm_dflt_t dflt;
    sbm_pins_t pins;
  } sbm_regs_t;

  localparam sbm_regs_t REGS_RESET = '{st: ST_DET, default: '0};
endpackage : sbm_pkg

// ---- rtl/sbm_loader.sv ----
/*
  Two-wire bus master with EEPROM default loader and software byte access.
  Assumes open-drain pads outside: an enable pulls the pad low, pullups fitted.
*/
`timescale 1ns/1ns
// last core tick of each quarter bit; the default gives close to 100 kHz
module sbm_loader #(
  parameter logic [7:0] QTR_LAST = sbm_pkg::QTR_LAST
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic latch_strap_n,
  input wire logic multifunction_terminal_four_i,
  input wire logic multifunction_terminal_one_i,
  output sbm_pkg::sbm_pins_t pins,
  input wire logic sw_start,
  input sbm_pkg::sbm_sw_req_t sw_req,
  input wire logic [7:0] sw_status_w1c,
  output logic [7:0] status,
  output logic [7:0] sw_rdata,
  input wire logic load_ready,
  output sbm_pkg::sbm_dflt_t defaults,
  output logic load_done
);
  sbm_pkg::sbm_regs_t r;
  sbm_pkg::sbm_regs_t n;
  logic sda_s;
  logic tick_end;
  logic bit_end;
  logic stall;
  logic push;
  logic pop;
  logic active;

  function automatic sbm_pkg::sbm_dflt_t apply_byte(
    input sbm_pkg::sbm_dflt_t d,
    input logic [3:0] off,
    input logic [7:0] b
  );
    sbm_pkg::sbm_dflt_t o;
    o = d;
    if (off == sbm_pkg::OFF_CMD)
    begin
      o.command[8] = b[7];
      o.command[6:5] = b[6:5];
      o.command[2:0] = b[2:0];
    end
    else if (off == sbm_pkg::OFF_SVID_LO)
      o.ss_vendor_id[7:0] = b;
    else if (off == sbm_pkg::OFF_SVID_HI)
      o.ss_vendor_id[15:8] = b;
    else if (off == sbm_pkg::OFF_SID_LO)
      o.ss_id[7:0] = b;
    else if (off == sbm_pkg::OFF_SID_HI)
      o.ss_id[15:8] = b;
    else if (off == sbm_pkg::OFF_LEG0)
      o.legacy_base[7:1] = b[7:1];
    else if (off == sbm_pkg::OFF_LEG1)
      o.legacy_base[15:8] = b;
    else if (off == sbm_pkg::OFF_LEG2)
      o.legacy_base[23:16] = b;
    else if (off == sbm_pkg::OFF_LEG3)
      o.legacy_base[31:24] = b;
    else if (off == sbm_pkg::OFF_SYS_LO)
      o.sys_ctrl[7:0] = b;
    else if (off == sbm_pkg::OFF_LAST)
      o.sys_ctrl[15:8] = b;
    return o;
  endfunction : apply_byte

  always_comb
  begin
    n = r;
    // synchroniser: sy1 feeds only sy2
    n.sy1 = {latch_strap_n, multifunction_terminal_four_i, multifunction_terminal_one_i};
    n.sy2 = r.sy1;
    sda_s = r.sy2[0];
    push = 1'b0;
    pop = (r.fn != 2'b00) && load_ready;
    // hold the clock low rather than drop a byte the consumer cannot take
    stall = (r.st == sbm_pkg::ST_RX) && r.ld && (r.fn == 2'b10) && (r.q == 2'b00) &&
      (r.tick == 8'h00) && (r.bitn == 3'b000);
    tick_end = (r.tick == QTR_LAST);
    bit_end = tick_end && (r.q == 2'b11);
    active = (r.st != sbm_pkg::ST_IDLE) && (r.st != sbm_pkg::ST_DET);
    n.csr = r.csr & ~(sw_status_w1c & sbm_pkg::CS_W1C_MASK);
    if (active && !stall)
    begin
      n.tick = tick_end ? 8'h00 : r.tick + 8'h01;
      if (tick_end)
        n.q = r.q + 2'b01;
    end
    case (r.st)
      // strap and lines are judged once; a late pullup is never seen
      sbm_pkg::ST_DET:
      begin
        n.det_cnt = r.det_cnt + 4'h1;
        if (r.det_cnt == sbm_pkg::DET_LAST)
        begin
          if (!r.sy2[2] && r.sy2[1] && r.sy2[0])
          begin
            n.en = 1'b1;
            n.csr[sbm_pkg::CS_BUS_DETECTED_FLAG] = 1'b1;
            n.ld = 1'b1;
            n.req.slave_addr = {sbm_pkg::EE_ADDR7, 1'b0};
            n.req.index = sbm_pkg::EE_FIRST;
            n.wr = 1'b0;
            n.cnt = sbm_pkg::OFF_FLAG;
            n.ph = 3'b000;
            n.st = sbm_pkg::ST_START;
          end
          else
          begin
            n.st = sbm_pkg::ST_IDLE;
            n.ldone = 1'b1;
          end
        end
      end
      // loader keeps busy until the consumer has drained every byte
      sbm_pkg::ST_IDLE:
      begin
        if (r.ld)
        begin
          if (r.fn == 2'b00)
          begin
            n.ld = 1'b0;
            n.ldone = 1'b1;
          end
        end
        else if (sw_start && r.en)
        begin
          n.req = sw_req;
          n.wr = ~sw_req.slave_addr[0];
          n.csr[sbm_pkg::CS_RD_VALID] = 1'b0;
          n.ph = 3'b000;
          n.st = sbm_pkg::ST_START;
        end
      end
      sbm_pkg::ST_START:
      begin
        if (bit_end)
        begin
          n.st = sbm_pkg::ST_TX;
          n.bitn = 3'b000;
          n.sh = {r.req.slave_addr[7:1], r.ph == 3'b011};
        end
      end
      // shift out msb first; the pad follows sh[7] from quarter one
      sbm_pkg::ST_TX:
      begin
        if (bit_end)
        begin
          n.sh = {r.sh[6:0], 1'b0};
          n.bitn = r.bitn + 3'b001;
          if (r.bitn == 3'b111)
            n.st = sbm_pkg::ST_RXACK;
        end
      end
      sbm_pkg::ST_RXACK:
      begin
        // sampled at the end of quarter two, mid-way through the high phase, past the synchroniser delay
        if (tick_end && (r.q == 2'b10))
          n.nack = sda_s;
        if (bit_end)
        begin
          n.bitn = 3'b000;
          if (r.nack)
          begin
            n.csr[sbm_pkg::CS_ERROR] = 1'b1;
            n.st = sbm_pkg::ST_STOP;
          end
          else if (r.ph == 3'b000)
          begin
            n.ph = 3'b001;
            n.sh = r.req.index;
            n.st = sbm_pkg::ST_TX;
          end
          else if (r.ph == 3'b001)
          begin
            if (r.wr)
            begin
              n.ph = 3'b010;
              n.sh = r.req.wdata;
              n.st = sbm_pkg::ST_TX;
            end
            else
            begin
              n.ph = 3'b011;
              n.st = sbm_pkg::ST_START;
            end
          end
          else if (r.ph == 3'b010)
            n.st = sbm_pkg::ST_STOP;
          else
          begin
            n.ph = 3'b100;
            n.st = sbm_pkg::ST_RX;
          end
        end
      end
      // the flag byte is buffered too; its offset loads no field
      sbm_pkg::ST_RX:
      begin
        if (tick_end && (r.q == 2'b10))
          n.sh = {r.sh[6:0], sda_s};
        if (bit_end)
        begin
          n.bitn = r.bitn + 3'b001;
          if (r.bitn == 3'b111)
          begin
            n.st = sbm_pkg::ST_TXACK;
            if (r.ld)
            begin
              push = 1'b1;
              n.last = (r.cnt == sbm_pkg::OFF_LAST) ||
                ((r.cnt == sbm_pkg::OFF_FLAG) && (r.sh != sbm_pkg::FLAG_LOAD));
            end
            else
            begin
              n.last = 1'b1;
              n.rdata = r.sh;
              n.csr[sbm_pkg::CS_RD_VALID] = 1'b1;
            end
          end
        end
      end
      sbm_pkg::ST_TXACK:
      begin
        if (bit_end)
        begin
          if (r.last)
            n.st = sbm_pkg::ST_STOP;
          else
          begin
            n.cnt = r.cnt + 4'h1;
            n.bitn = 3'b000;
            n.st = sbm_pkg::ST_RX;
          end
        end
      end
      // no clock stretching: a slave holding the clock low goes unseen
      sbm_pkg::ST_STOP:
      begin
        if (bit_end)
          n.st = sbm_pkg::ST_IDLE;
      end
      default:
        n.st = sbm_pkg::ST_IDLE;
    endcase
    // two-entry buffer between received EEPROM bytes and the defaults
    if (push)
    begin
      n.fifo[r.wp] = {r.cnt, r.sh};
      n.wp = ~r.wp;
    end
    if (pop)
    begin
      n.dflt = apply_byte(r.dflt, r.fifo[r.rp][11:8], r.fifo[r.rp][7:0]);
      n.rp = ~r.rp;
    end
    n.fn = r.fn + {1'b0, push} - {1'b0, pop};
    n.csr[sbm_pkg::CS_BUSY] = ((n.st != sbm_pkg::ST_IDLE) && (n.st != sbm_pkg::ST_DET)) || n.ld;
    // pads: enable pulls low, released lines float high via pullups
    // the data levels stay low; only the enables move
    n.pins.multifunction_terminal_four_o = 1'b0;
    n.pins.multifunction_terminal_one_o = 1'b0;
    n.pins.multifunction_terminal_four_oe = (n.st != sbm_pkg::ST_IDLE) &&
      (n.st != sbm_pkg::ST_DET) && (n.q < 2'b10);
    if (n.st == sbm_pkg::ST_IDLE || n.st == sbm_pkg::ST_DET)
      n.pins.multifunction_terminal_one_oe = 1'b0;
    else if (n.q != 2'b00)
    begin
      case (n.st)
        sbm_pkg::ST_START:
          n.pins.multifunction_terminal_one_oe = (n.q == 2'b11);
        sbm_pkg::ST_STOP:
          n.pins.multifunction_terminal_one_oe = (n.q != 2'b11);
        sbm_pkg::ST_TX:
          n.pins.multifunction_terminal_one_oe = ~n.sh[7];
        sbm_pkg::ST_TXACK:
          n.pins.multifunction_terminal_one_oe = ~n.last;
        default:
          n.pins.multifunction_terminal_one_oe = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      r <= sbm_pkg::REGS_RESET;
    else
      r <= n;
  end

  assign pins = r.pins;
  assign status = r.csr;
  assign sw_rdata = r.rdata;
  assign defaults = r.dflt;
  assign load_done = r.ldone;
endmodule : sbm_loader

// ---- verification/sbm_loader_asserts.sv ----
/*
  Port-level checks on the serial-bus master and loader.
  Assumes the loader's core clock and synchronous reset; bound below.
*/
`timescale 1ns/1ns
module sbm_chk #(
  parameter logic [7:0] QTR_LAST = sbm_pkg::QTR_LAST
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic latch_strap_n,
  input wire logic multifunction_terminal_four_i,
  input wire logic multifunction_terminal_one_i,
  input sbm_pkg::sbm_pins_t pins,
  input wire logic sw_start,
  input sbm_pkg::sbm_sw_req_t sw_req,
  input wire logic [7:0] sw_status_w1c,
  input wire logic [7:0] status,
  input wire logic [7:0] sw_rdata,
  input wire logic load_ready,
  input sbm_pkg::sbm_dflt_t defaults,
  input wire logic load_done
);
  localparam int QCYC = QTR_LAST + 1;
  localparam int STOP_MAX = QCYC + 2;
  localparam int HIGH_MAX = 2 * QCYC + 2;
  localparam int NACK_MAX = 4 * QCYC + 2;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  wire logic scl_low = pins.multifunction_terminal_four_oe;
  wire logic sda_low = pins.multifunction_terminal_one_oe;
  // cycles since a missing acknowledge while the bus is still busy
  logic [11:0] nack_wait_ff;
  always_ff @(posedge core_clk)
  begin
    if (rst || !status[5])
      nack_wait_ff <= 12'h000;
    else if ($rose(status[1]) || (nack_wait_ff != 12'h000))
      nack_wait_ff <= nack_wait_ff + 12'h001;
  end
  a_idle_released: assert property (
    !status[5] && !$past(status[5]) |-> !scl_low && !sda_low)
    else $error("line driven while idle");
  a_start_cond: assert property (
    $rose(sda_low) && !scl_low |-> ##QCYC scl_low)
    else $error("start not followed by first bit");
  a_stop_cond: assert property (
    $fell(sda_low) && !scl_low |-> ##[1:STOP_MAX] !status[5])
    else $error("data rose with clock high outside stop");
  a_scl_high_len: assert property (
    $fell(scl_low) |-> ##[1:HIGH_MAX] (scl_low || !status[5]))
    else $error("clock high phase too long");
  a_busy_on_start: assert property (
    sw_start && !status[5] && status[3] |=> status[5])
    else $error("software start not taken");
  a_detect_w1c: assert property (
    load_done && sw_status_w1c[3] |=> !status[3])
    else $error("detected flag not cleared");
  a_nack_stop: assert property (
    nack_wait_ff <= NACK_MAX)
    else $error("no stop after missing ack");
  a_fixed_bits: assert property (
    !defaults.legacy_base[0] && !defaults.command[7] && defaults.command[4:3] == 2'b00)
    else $error("unloadable default bit set");
endmodule : sbm_chk
bind sbm_loader sbm_chk #(.QTR_LAST(QTR_LAST)) i_chk (.*);

// ---- verification/sbm_ee_model.sv ----
/*
  Behavioural two-wire EEPROM slave.
  Assumes wired lines with pullups; pull high holds data low.
*/
`timescale 1ns/1ns
module sbm_ee_model (
  input wire logic scl,
  input wire logic sda,
  output logic pull
);
  logic [7:0] mem [0:15];
  logic [7:0] sh;
  logic [7:0] tx;
  logic [3:0] ptr;
  logic act;
  logic rd;
  int bitc;
  int byten;
  initial
  begin
    pull = 1'b0;
    act = 1'b0;
    rd = 1'b0;
    bitc = 0;
    byten = 0;
    ptr = 4'h0;
    mem = '{8'h01, 8'hBD, 8'h11, 8'h22, 8'h33, 8'h44, 8'h57, 8'h66,
      8'h77, 8'h88, 8'h99, 8'hAA, 8'h00, 8'h00, 8'h00, 8'h00};
  end
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      bitc = 0;
      byten = 0;
      rd = 1'b0;
    end
  always @(posedge sda)
    if (scl === 1'b1)
      act = 1'b0;
  always @(posedge scl)
  begin
    bitc++;
    if (rd && byten > 0)
    begin
      if (bitc == 9 && sda)
        act = 1'b0;
      else if (bitc == 9)
      begin
        ptr++;
        tx = mem[ptr];
      end
    end
    else if (bitc <= 8)
    begin
      sh = {sh[6:0], sda};
      if (bitc == 8 && byten == 0)
      begin
        act = (sh[7:1] == 7'h50);
        rd = sh[0];
        tx = mem[ptr];
      end
      else if (bitc == 8 && byten == 1 && act)
        ptr = sh[3:0];
      else if (bitc == 8 && act)
      begin
        mem[ptr] = sh;
        ptr++;
      end
    end
  end
  always @(negedge scl)
    if (bitc == 9)
    begin
      bitc = 0;
      byten++;
      pull = rd && act && !tx[7];
    end
    else if (bitc == 8)
      pull = act && !(rd && byten > 0);
    else if (rd && act && byten > 0 && bitc > 0)
      pull = !tx[7 - bitc];
endmodule : sbm_ee_model

// ---- verification/testbench.sv ----
/*
  Bench: EEPROM load with stalled consumer, software access, absent interface.
  Assumes loader, checker and EEPROM model compiled first.
*/
`timescale 1ns/1ns
module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic latch_strap_n = 1'b0;
  logic sw_start = 1'b0;
  logic load_ready = 1'b0;
  logic [7:0] sw_status_w1c = 8'h00;
  logic [7:0] status;
  logic [7:0] sw_rdata;
  logic load_done;
  logic ee_pull;
  sbm_pkg::sbm_sw_req_t sw_req = '0;
  sbm_pkg::sbm_pins_t pins;
  sbm_pkg::sbm_dflt_t dflt;
  int bad_count = 0;
  int comparisons = 0;
  // pullups: a released line reads high
  wire logic scl = ~pins.multifunction_terminal_four_oe;
  wire logic sda = ~(pins.multifunction_terminal_one_oe | ee_pull);
  always #5 core_clk = ~core_clk;
  sbm_loader #(.QTR_LAST(8'h03)) i_dut (.core_clk(core_clk), .rst(rst),
    .latch_strap_n(latch_strap_n),
    .multifunction_terminal_four_i(scl), .multifunction_terminal_one_i(sda), .pins(pins),
    .sw_start(sw_start), .sw_req(sw_req), .sw_status_w1c(sw_status_w1c), .status(status),
    .sw_rdata(sw_rdata), .load_ready(load_ready), .defaults(dflt), .load_done(load_done));
  sbm_ee_model i_ee (.scl(scl), .sda(sda), .pull(ee_pull));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic sw_op(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sw_start <= 1'b1;
    sw_req <= '{slave_addr: a, index: 8'h03, wdata: d};
    @(posedge core_clk);
    sw_start <= 1'b0;
    @(negedge core_clk);
    while (status[5] !== 1'b0)
      @(negedge core_clk);
  endtask : sw_op
  task automatic clear(input logic [7:0] m);
    @(posedge core_clk);
    sw_status_w1c <= m;
    @(posedge core_clk);
    sw_status_w1c <= 8'h00;
    @(negedge core_clk);
  endtask : clear
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    conclude();
  end
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    // consumer stalls first, so the buffer fills and the engine must wait
    repeat (2000) @(posedge core_clk);
    load_ready <= 1'b1;
    while (load_done !== 1'b1)
      @(negedge core_clk);
    chk("command", 32'(dflt.command), 32'h0000_0125);
    chk("ss_vendor_id", 32'(dflt.ss_vendor_id), 32'h0000_2211);
    chk("ss_id", 32'(dflt.ss_id), 32'h0000_4433);
    chk("legacy_base", dflt.legacy_base, 32'h8877_6656);
    chk("sys_ctrl", 32'(dflt.sys_ctrl), 32'h0000_AA99);
    chk("status", 32'(status), 32'h0000_0008);
    $display("test load done");
    sw_op(8'hA0, 8'h5C);
    chk("ee byte", 32'(i_ee.mem[3]), 32'h0000_005C);
    chk("status", 32'(status), 32'h0000_0008);
    clear(8'h08);
    chk("status", 32'(status), 32'h0000_0000);
    sw_op(8'hA1, 8'h00);
    chk("sw_rdata", 32'(sw_rdata), 32'h0000_005C);
    chk("status", 32'(status), 32'h0000_0001);
    sw_op(8'hA4, 8'h00);
    chk("status", 32'(status), 32'h0000_0002);
    clear(8'h03);
    chk("status", 32'(status), 32'h0000_0000);
    $display("test software access done");
    @(posedge core_clk);
    latch_strap_n <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (40) @(negedge core_clk);
    chk("load_done", 32'(load_done), 32'h0000_0001);
    sw_op(8'hA0, 8'h11);
    chk("status", 32'(status), 32'h0000_0000);
    chk("ee byte", 32'(i_ee.mem[3]), 32'h0000_005C);
    chk("legacy_base", dflt.legacy_base, 32'h0000_0000);
    $display("test absent interface done");
    conclude();
  end
endmodule : testbench
